/* File: inc/tcv_defs.svh */
// Offsets, field positions and reset values of the channel value block
`ifndef TCV_DEFS_SVH
`define TCV_DEFS_SVH
`define TCV_OFF_CH1 12'h038
`define TCV_OFF_CH2 12'h03C
`define TCV_OFF_CH3 12'h040
`define TCV_OFF_CTRL 12'h050
`define TCV_OFF_STAT 12'h054
`define TCV_RESET_VALUE 32'h0000_0000
`define TCV_NARROW_MASK 32'h0000_FFFF
`define TCV_FULL_MASK 32'hFFFF_FFFF
`define TCV_CTRL_MODE_LSB 0
`define TCV_CTRL_SHADOW_LSB 3
`define TCV_CTRL_UPDDIS_BIT 6
`define TCV_CTRL_RESET 32'h0000_0000
`define TCV_NUM_CH 3
`endif

/* File: inc/tcv_pkg.sv */
// Types shared by the channel value block
package tcv_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic write;
        logic [31:0] wdata;
    } tcv_req_t;
    typedef enum logic {TCV_MODE_OUTPUT, TCV_MODE_INPUT} tcv_mode_t;
    typedef enum {TCV_IDLE, TCV_ACCESS} tcv_state_t;
endpackage : tcv_pkg

/* File: rtl/tcv_capcmp.sv */
// Channel 1..3 capture/compare value registers with APB slave and update logic
// Summary of operation
// - In input mode the register shows the counter latched at the last capture.
// - In input mode software writes do not change the captured value.
// - In output mode the register holds a compare value matched against the counter.
// - With shadowing on, the active compare value reloads only at update events.
// - Wide instance uses all 32 bits for the value field.
// - Narrow instance uses bits 15:0; upper bits stay zero.
// - All value registers reset to zero.
// - Channel 1, 2, 3 registers sit at offsets 0x38, 0x3C, 0x40.
// - Channel 3 behaves like the others with its own register.
// - An update event occurs at each up-counting overflow or software request unless the update disable bit is set, and reloads shadows.
//
// Register access over APB was left to the implementer.
`timescale 1ns/1ns
`include "tcv_defs.svh"
module tcv_capcmp
    import tcv_pkg::*;
#(
    parameter bit WIDE = 1'b1
)
(
    input wire logic I_CLOCK,
    input wire logic I_RESETN,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [31:0] i_counter,
    input wire logic i_overflow,
    input wire logic i_sw_update,
    input wire logic [2:0] i_capture,
    output logic [2:0] o_match,
    output logic o_update
);
    localparam logic [31:0] MASK = WIDE ? `TCV_FULL_MASK : `TCV_NARROW_MASK;

    logic [31:0] ctrl;
    logic [2:0] capture_seen;
    logic [31:0] value [3];
    logic [31:0] active [3];
    logic [2:0] wr_ch;
    logic access;
    logic mapped;
    logic [31:0] next_prdata;
    tcv_req_t req;

    function automatic logic [1:0] ch_index(input logic [11:0] a);
        if (a == `TCV_OFF_CH1) begin
            ch_index = 2'h0;
        end else if (a == `TCV_OFF_CH2) begin
            ch_index = 2'h1;
        end else begin
            ch_index = 2'h2;
        end
    endfunction : ch_index

    function automatic logic is_ch(input logic [11:0] a);
        is_ch = (a == `TCV_OFF_CH1) || (a == `TCV_OFF_CH2) || (a == `TCV_OFF_CH3);
    endfunction : is_ch

    assign req = '{addr: i_paddr, write: i_pwrite, wdata: i_pwdata};
    assign access = i_psel && i_penable;
    assign o_pready = 1'b1;
    assign mapped = is_ch(req.addr) || (req.addr == `TCV_OFF_CTRL) || (req.addr == `TCV_OFF_STAT);
    assign o_pslverr = access && !mapped;

    // Update event from overflow or software request, masked by the disable bit
    assign o_update = (i_overflow || i_sw_update) && !ctrl[`TCV_CTRL_UPDDIS_BIT];

    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            ctrl <= `TCV_CTRL_RESET;
        end else if (access && req.write && req.addr == `TCV_OFF_CTRL) begin
            ctrl <= req.wdata;
        end
    end

    // Sticky capture record, cleared by writing ones; a new capture wins
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            capture_seen <= 3'b000;
        end else begin
            for (int i = 0; i < `TCV_NUM_CH; i++) begin
                if (ctrl[`TCV_CTRL_MODE_LSB + i] && i_capture[i]) begin
                    capture_seen[i] <= 1'b1;
                end else if (access && req.write && req.addr == `TCV_OFF_STAT && req.wdata[i]) begin
                    capture_seen[i] <= 1'b0;
                end
            end
        end
    end

    always_comb begin
        wr_ch = 3'b000;
        if (access && req.write && is_ch(req.addr)) begin
            wr_ch[ch_index(req.addr)] = 1'b1;
        end
    end

    for (genvar g = 0; g < 3; g++) begin : g_ch
        tcv_channel u_ch (
            .i_clock(I_CLOCK),
            .i_resetn(I_RESETN),
            .i_mask(MASK),
            .i_mode(ctrl[`TCV_CTRL_MODE_LSB + g] ? TCV_MODE_INPUT : TCV_MODE_OUTPUT),
            .i_shadow_en(ctrl[`TCV_CTRL_SHADOW_LSB + g]),
            .i_update(o_update),
            .i_capture(i_capture[g]),
            .i_counter(i_counter),
            .i_wr(wr_ch[g]),
            .i_wdata(req.wdata),
            .o_value(value[g]),
            .o_active(active[g]),
            .o_match(o_match[g])
        );
    end

    always_comb begin
        next_prdata = 32'h0000_0000;
        if (is_ch(req.addr)) begin
            next_prdata = value[ch_index(req.addr)];
        end else if (req.addr == `TCV_OFF_CTRL) begin
            next_prdata = ctrl;
        end else if (req.addr == `TCV_OFF_STAT) begin
            next_prdata = {29'h0000_0000, capture_seen};
        end
    end

    // Read data registered in the setup cycle, valid in the access cycle
    always_ff @(posedge I_CLOCK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            o_prdata <= `TCV_RESET_VALUE;
        end else if (i_psel && !i_penable && !i_pwrite) begin
            o_prdata <= next_prdata;
        end
    end

    // Input mode: the register holds the last captured counter and ignores writes
    a_input_readonly: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB] && !i_capture[0]) |=> value[0] == $past(value[0]))
        else $error("Input-mode value changed without capture");

    a_readonly_ch2: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB + 1] && !i_capture[1]) |=> value[1] == $past(value[1]))
        else $error("Channel 2 input-mode value changed without capture");

    a_readonly_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB + 2] && !i_capture[2]) |=> value[2] == $past(value[2]))
        else $error("Channel 3 input-mode value changed without capture");

    a_capture_latch: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB] && i_capture[0]) |=> value[0] == ($past(i_counter) & MASK))
        else $error("Capture did not latch counter");

    a_capture_ch2: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB + 1] && i_capture[1])
        |=> value[1] == ($past(i_counter) & MASK))
        else $error("Channel 2 capture did not latch counter");

    a_capture_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB + 2] && i_capture[2])
        |=> value[2] == ($past(i_counter) & MASK))
        else $error("Channel 3 capture did not latch counter");

    a_capture_seen: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_MODE_LSB] && i_capture[0]) |=> capture_seen[0])
        else $error("Capture not recorded in status");

    // Output mode: stored compare value, shadow reload and match
    a_outmode_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (!ctrl[`TCV_CTRL_MODE_LSB] && !wr_ch[0]) |=> value[0] == $past(value[0]))
        else $error("Output-mode value changed without write");

    a_outmode_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (!ctrl[`TCV_CTRL_MODE_LSB + 2] && !wr_ch[2]) |=> value[2] == $past(value[2]))
        else $error("Channel 3 output-mode value changed without write");

    a_shadow_hold: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_SHADOW_LSB] && !ctrl[`TCV_CTRL_MODE_LSB] && !o_update)
        |=> active[0] == $past(active[0]))
        else $error("Shadowed compare changed outside update");

    a_hold_ch2: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_SHADOW_LSB + 1] && !ctrl[`TCV_CTRL_MODE_LSB + 1] && !o_update)
        |=> active[1] == $past(active[1]))
        else $error("Channel 2 shadowed compare changed outside update");

    a_hold_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_SHADOW_LSB + 2] && !ctrl[`TCV_CTRL_MODE_LSB + 2] && !o_update)
        |=> active[2] == $past(active[2]))
        else $error("Channel 3 shadowed compare changed outside update");

    a_shadow_load: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_SHADOW_LSB] && !ctrl[`TCV_CTRL_MODE_LSB] && o_update)
        |=> active[0] == $past(value[0]))
        else $error("Update did not load compare");

    a_load_ch2: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_SHADOW_LSB + 1] && !ctrl[`TCV_CTRL_MODE_LSB + 1] && o_update)
        |=> active[1] == $past(value[1]))
        else $error("Update did not load channel 2 compare");

    a_load_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (ctrl[`TCV_CTRL_SHADOW_LSB + 2] && !ctrl[`TCV_CTRL_MODE_LSB + 2] && o_update)
        |=> active[2] == $past(value[2]))
        else $error("Update did not load channel 3 compare");

    a_direct_write: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (wr_ch[2] && !ctrl[`TCV_CTRL_SHADOW_LSB + 2] && !ctrl[`TCV_CTRL_MODE_LSB + 2]
        && !$changed(ctrl))
        |=> ##1 active[2] == ($past(req.wdata, 2) & MASK))
        else $error("Unshadowed write not active next cycle");

    a_direct_ch1: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (wr_ch[0] && !ctrl[`TCV_CTRL_SHADOW_LSB] && !ctrl[`TCV_CTRL_MODE_LSB]
        && !$changed(ctrl))
        |=> ##1 active[0] == ($past(req.wdata, 2) & MASK))
        else $error("Channel 1 unshadowed write not active next cycle");

    a_direct_ch2: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (wr_ch[1] && !ctrl[`TCV_CTRL_SHADOW_LSB + 1] && !ctrl[`TCV_CTRL_MODE_LSB + 1]
        && !$changed(ctrl))
        |=> ##1 active[1] == ($past(req.wdata, 2) & MASK))
        else $error("Channel 2 unshadowed write not active next cycle");

    a_match_flag: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (!ctrl[`TCV_CTRL_MODE_LSB] && (i_counter & MASK) == active[0]) |=> o_match[0])
        else $error("Counter equal to compare value gave no match");

    a_match_off: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        ctrl[`TCV_CTRL_MODE_LSB] |=> !o_match[0])
        else $error("Match flagged in input mode");

    // Register map and bus answer
    a_ch1_decode: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (access && req.write && req.addr == `TCV_OFF_CH1 && !ctrl[`TCV_CTRL_MODE_LSB])
        |=> value[0] == ($past(req.wdata) & MASK))
        else $error("Write at channel 1 offset not stored");

    a_ch2_decode: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (access && req.write && req.addr == `TCV_OFF_CH2 && !ctrl[`TCV_CTRL_MODE_LSB + 1])
        |=> value[1] == ($past(req.wdata) & MASK))
        else $error("Write at channel 2 offset not stored");

    a_ch3_decode: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (access && req.write && req.addr == `TCV_OFF_CH3 && !ctrl[`TCV_CTRL_MODE_LSB + 2])
        |=> value[2] == ($past(req.wdata) & MASK))
        else $error("Write at channel 3 offset not stored");

    a_read_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (i_psel && !i_penable && !i_pwrite && req.addr == `TCV_OFF_CH3)
        |=> o_prdata == $past(value[2]))
        else $error("Read of channel 3 offset returned wrong data");

    a_slverr_mapped: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (access && is_ch(req.addr)) |-> !o_pslverr)
        else $error("Error answer at a channel offset");

    a_slverr_unmapped: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (access && !is_ch(req.addr) && req.addr != `TCV_OFF_CTRL && req.addr != `TCV_OFF_STAT)
        |-> o_pslverr)
        else $error("No error answer at an unmapped offset");

    // Value field width of each instance
    a_narrow_ch1: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (value[0] & ~MASK) == `TCV_RESET_VALUE)
        else $error("Upper bits set in channel 1 narrow value");

    a_narrow_upper: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (value[1] & ~MASK) == `TCV_RESET_VALUE)
        else $error("Upper bits set in narrow value");

    a_narrow_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (value[2] & ~MASK) == `TCV_RESET_VALUE)
        else $error("Upper bits set in channel 3 narrow value");

    a_wide_full: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN || !WIDE)
        (wr_ch[0] && !ctrl[`TCV_CTRL_MODE_LSB]) |=> value[0] == $past(req.wdata))
        else $error("Wide write lost bits");

    a_wide_ch2: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN || !WIDE)
        (wr_ch[1] && !ctrl[`TCV_CTRL_MODE_LSB + 1]) |=> value[1] == $past(req.wdata))
        else $error("Wide channel 2 write lost bits");

    a_wide_ch3: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN || !WIDE)
        (wr_ch[2] && !ctrl[`TCV_CTRL_MODE_LSB + 2]) |=> value[2] == $past(req.wdata))
        else $error("Wide channel 3 write lost bits");

    // Update events and reset state
    a_overflow_update: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        (i_overflow && !ctrl[`TCV_CTRL_UPDDIS_BIT]) |-> o_update)
        else $error("Overflow gave no update");

    a_update_off: assert property (@(posedge I_CLOCK) disable iff (!I_RESETN)
        ctrl[`TCV_CTRL_UPDDIS_BIT] |-> !o_update)
        else $error("Update event while updates are disabled");

    a_reset_zero: assert property (@(posedge I_CLOCK)
        $rose(I_RESETN) |-> (value[0] | value[1] | value[2]) == `TCV_RESET_VALUE)
        else $error("Value not zero after reset");

    a_reset_active: assert property (@(posedge I_CLOCK)
        $rose(I_RESETN) |-> (active[0] | active[1] | active[2]) == `TCV_RESET_VALUE)
        else $error("Compare value not zero after reset");
endmodule : tcv_capcmp

/* File: rtl/tcv_channel.sv */
// One capture/compare channel: captured value, preload value and active compare value
`timescale 1ns/1ns
`include "tcv_defs.svh"
module tcv_channel
    import tcv_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic [31:0] i_mask,
    input wire tcv_mode_t i_mode,
    input wire logic i_shadow_en,
    input wire logic i_update,
    input wire logic i_capture,
    input wire logic [31:0] i_counter,
    input wire logic i_wr,
    input wire logic [31:0] i_wdata,
    output logic [31:0] o_value,
    output logic [31:0] o_active,
    output logic o_match
);
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_value <= `TCV_RESET_VALUE;
        end else if (i_mode == TCV_MODE_INPUT) begin
            if (i_capture) begin
                o_value <= i_counter & i_mask;
            end
        end else if (i_wr) begin
            o_value <= i_wdata & i_mask;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_active <= `TCV_RESET_VALUE;
        end else if (i_mode == TCV_MODE_OUTPUT) begin
            if (!i_shadow_en) begin
                o_active <= o_value;
            end else if (i_update) begin
                o_active <= o_value;
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_match <= 1'b0;
        end else begin
            o_match <= (i_mode == TCV_MODE_OUTPUT) && ((i_counter & i_mask) == o_active);
        end
    end
endmodule : tcv_channel

/* File: verification/tcv_capcmp_tb_top.sv */
// Self-checking bench for the wide and narrow channel value block
`timescale 1ns/1ns
module tcv_capcmp_tb_top;
    logic clk = 1'h0;
    logic rstn = 1'h0;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] counter = 32'h0;
    logic ovf = 1'h0;
    logic swu = 1'h0;
    logic [2:0] cap = 3'h0;
    logic [31:0] rd_w, rd_n, rdata_w, rdata_n;
    logic rdy_w, rdy_n, err_w, err_n, upd_w, upd_n;
    logic [1:0] err_last;
    logic [2:0] m_w, m_n;
    logic [11:0] offs [3] = '{12'h038, 12'h03C, 12'h040};
    int error_cnt = 0;
    int checked = 0;
    int cycles = 0;
    always #25 clk = ~clk;
    tcv_capcmp #(.WIDE(1'h1)) DUT (.I_CLOCK(clk), .I_RESETN(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(rd_w), .o_pready(rdy_w), .o_pslverr(err_w), .i_counter(counter),
        .i_overflow(ovf), .i_sw_update(swu), .i_capture(cap), .o_match(m_w), .o_update(upd_w));
    tcv_capcmp #(.WIDE(1'h0)) DUT_N (.I_CLOCK(clk), .I_RESETN(rstn), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(rd_n), .o_pready(rdy_n), .o_pslverr(err_n), .i_counter(counter),
        .i_overflow(ovf), .i_sw_update(swu), .i_capture(cap), .o_match(m_n), .o_update(upd_n));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // One APB transfer to both instances; returns at the edge that completes it
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (!(rdy_w && rdy_n)) @(posedge clk);
        rdata_w = rd_w;
        rdata_n = rd_n;
        err_last = {err_w, err_n};
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rd(input logic [11:0] a, input logic [31:0] ew, input logic [31:0] en);
        apb(1'h0, a, 32'h0);
        chk(rdata_w, ew);
        chk(rdata_n, en);
    endtask : rd
    task automatic t_reset();
        chk({rdy_w, rdy_n, m_w, m_n}, 8'hC0);
        for (int i = 0; i < 3; i++) rd(offs[i], 32'h0, 32'h0);
    endtask : t_reset
    task automatic t_write();
        logic [31:0] v;
        for (int i = 0; i < 3; i++) begin
            v = 32'hF0E1_D2C3 ^ (i * 32'h1111_1111);
            apb(1'h1, offs[i], v);
            rd(offs[i], v, v & 32'h0000_FFFF);
        end
    endtask : t_write
    task automatic t_match();
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            counter <= 32'h1230 + i;
            apb(1'h1, offs[i], 32'h1230 + i);
            @(posedge clk);
            #1 chk({m_w, m_n}, 6'h0);
            @(posedge clk);
            #1 chk({m_w, m_n}, {3'h1 << i, 3'h1 << i});
        end
    endtask : t_match
    task automatic t_shadow();
        apb(1'h1, 12'h050, 32'h38);
        counter <= 32'h0777;
        for (int i = 0; i < 2; i++) begin
            apb(1'h1, offs[i], 32'h0777);
            repeat (3) @(posedge clk);
            #1 chk(m_w[i], 1'h0);
            @(posedge clk);
            if (i == 0) ovf <= 1'h1;
            else swu <= 1'h1;
            #1 chk({upd_w, upd_n}, 2'h3);
            @(posedge clk);
            ovf <= 1'h0;
            swu <= 1'h0;
            repeat (3) @(posedge clk);
            #1 chk({m_w[i], m_n[i]}, 2'h3);
        end
        // Update disable bit set: an overflow must not raise the update event
        apb(1'h1, 12'h050, 32'h78);
        @(posedge clk);
        ovf <= 1'h1;
        #1 chk({upd_w, upd_n}, 2'h0);
        @(posedge clk);
        ovf <= 1'h0;
    endtask : t_shadow
    task automatic t_capture();
        apb(1'h1, 12'h050, 32'h07);
        counter <= 32'hBEEF_1234;
        @(posedge clk);
        cap <= 3'h7;
        @(posedge clk);
        cap <= 3'h0;
        for (int i = 0; i < 3; i++) begin
            rd(offs[i], 32'hBEEF_1234, 32'h1234);
            apb(1'h1, offs[i], 32'h5555_5555);
            rd(offs[i], 32'hBEEF_1234, 32'h1234);
        end
        rd(12'h054, 32'h7, 32'h7);
        apb(1'h1, 12'h054, 32'h1);
        rd(12'h054, 32'h6, 32'h6);
    endtask : t_capture
    task automatic t_unmapped();
        rd(12'h044, 32'h0, 32'h0);
        chk(err_last, 2'h3);
        rd(offs[2], 32'hBEEF_1234, 32'h1234);
        chk(err_last, 2'h0);
    endtask : t_unmapped
    task automatic report_and_stop();
        $display("TB: errors=%0d checks=%0d", error_cnt, checked);
        if (error_cnt == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'h1;
        t_reset();
        t_write();
        t_match();
        t_shadow();
        t_capture();
        t_unmapped();
        report_and_stop();
    end
endmodule : tcv_capcmp_tb_top
